// ### pldc_pkg.sv
// Constants shared by the programmable logic datapath cell.
// Assumes an 8-bit system bus with a 5-bit register address.
package pldc_pkg;
  // Register addresses
  localparam logic [4:0] ADDR_ACC0 = 5'h00;
  localparam logic [4:0] ADDR_OPR0 = 5'h02;
  localparam logic [4:0] ADDR_BQ0 = 5'h04;
  localparam logic [4:0] ADDR_CFG = 5'h06;
  localparam logic [4:0] ADDR_MASK = 5'h07;
  localparam int STORE_SEL_BIT = 4;
  // Cell configuration fields
  localparam int CFG_BQ0_OUT = 0;
  localparam int CFG_DP_RUN = 2;
  localparam int CFG_PLD_RUN = 3;
  localparam int CFG_DP_RSEL = 4;
  localparam int CFG_PLD_RSEL = 5;
  localparam logic [7:0] CFG_RST = 8'h0C;
  localparam logic [7:0] MASK_RST = 8'h00;
  // Control word fields
  localparam int CW_FN_LSB = 0;
  localparam int CW_SRCA = 3;
  localparam int CW_SRCB_LSB = 4;
  localparam int CW_WR_ACC0 = 6;
  localparam int CW_SH_LSB = 8;
  localparam int CW_MASK = 10;
  localparam int CW_BQ0_OP = 11;
  localparam int CW_LD_OPR = 13;
  localparam int CW_PUSH_ALU = 14;
  localparam int CW_CHAIN_CI = 15;
  typedef enum logic [2:0] {
    ALU_PASS = 3'h0, ALU_INC = 3'h1, ALU_DEC = 3'h2, ALU_ADD = 3'h3,
    ALU_SUB = 3'h4, ALU_AND = 3'h5, ALU_OR = 3'h6, ALU_XOR = 3'h7
  } pldc_alu_e;
  typedef enum logic [1:0] {
    SH_NONE = 2'h0, SH_LEFT = 2'h1, SH_RIGHT = 2'h2, SH_SWAP = 2'h3
  } pldc_shift_e;
  typedef enum logic [1:0] {
    SRCB_OPR0 = 2'h0, SRCB_OPR1 = 2'h1, SRCB_ACC0 = 2'h2, SRCB_ACC1 = 2'h3
  } pldc_srcb_e;
endpackage : pldc_pkg

// ### pldc_cell.sv
// Programmable digital cell: two sum-of-products arrays and an 8-bit datapath.
// Assumes the bus, routing inputs and array configuration are synchronous to CLK_I.
`timescale 1ns/100ps
`default_nettype none
module pldc_cell
  import pldc_pkg::*;
#(
  parameter int NUM_PLD = 2,
  parameter int PLD_IN = 12,
  parameter int PLD_PT = 8,
  parameter int PLD_OUT = 4,
  parameter int BQ_DEPTH = 4
) (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic [4:0] BUS_ADDR_I,
  input wire logic BUS_WR_I,
  input wire logic BUS_RD_I,
  input wire logic [7:0] BUS_WDATA_I,
  output logic [7:0] BUS_RDATA_O,
  input wire logic [NUM_PLD*PLD_IN-1:0] PLD_IN_I,
  input wire logic [NUM_PLD*PLD_PT*PLD_IN-1:0] PT_USE_I,
  input wire logic [NUM_PLD*PLD_PT*PLD_IN-1:0] PT_INV_I,
  input wire logic [NUM_PLD*PLD_OUT*PLD_PT-1:0] SUM_SEL_I,
  input wire logic [NUM_PLD*PLD_OUT-1:0] OUT_REG_I,
  output logic [NUM_PLD*PLD_OUT-1:0] PLD_OUT_O,
  input wire logic [2:0] STORE_ADDR_I,
  input wire logic ROUTE_RESET_I,
  input wire logic CHAIN_CARRY_I,
  input wire logic CHAIN_SHIFT_I,
  output logic CHAIN_CARRY_O,
  output logic CHAIN_SHIFT_O,
  output logic [1:0] CMP_EQ_O,
  output logic [1:0] CMP_LT_O,
  output logic [1:0] ZERO_O,
  output logic [1:0] ONES_O,
  output logic OVFL_O,
  output logic [1:0] BQ_EMPTY_O,
  output logic [1:0] BQ_FULL_O
);
  localparam int PW = $clog2(BQ_DEPTH);
  localparam int CNW = $clog2(BQ_DEPTH + 1);

  logic [7:0] cfg_q, cfg_d, mask_q, mask_d, rdata_q, rdata_d;
  logic [15:0] store_q [8];
  logic [15:0] store_d [8];
  logic [7:0] acc_v [2];
  logic [7:0] opr_v [2];
  logic [7:0] head_v [2];
  logic [CNW-1:0] cnt_v [2];
  logic dp_run, dp_rst, pld_run, pld_rst;
  logic [15:0] cw;
  logic [7:0] op_a, op_b, alu, res;
  logic [8:0] sum9;
  logic cin, ovf, sh_out;

  // Clock and reset selection per part
  assign dp_run = cfg_q[CFG_DP_RUN];
  assign pld_run = cfg_q[CFG_PLD_RUN];
  assign dp_rst = cfg_q[CFG_DP_RSEL] & ROUTE_RESET_I;
  assign pld_rst = cfg_q[CFG_PLD_RSEL] & ROUTE_RESET_I;

  // Sum-of-products arrays
  for (genvar p = 0; p < NUM_PLD; p++) begin : g_pld
    logic [PLD_IN-1:0] in_v;
    logic [PLD_PT-1:0] pt;
    logic [PLD_OUT-1:0] sop, oreg_q, oreg_d, osel;
    assign in_v = PLD_IN_I[p*PLD_IN +: PLD_IN];
    assign osel = OUT_REG_I[p*PLD_OUT +: PLD_OUT];
    always_comb begin
      for (int t = 0; t < PLD_PT; t++) begin
        // An empty term stays false rather than true
        pt[t] = (|PT_USE_I[(p*PLD_PT+t)*PLD_IN +: PLD_IN]) &
                (&(~PT_USE_I[(p*PLD_PT+t)*PLD_IN +: PLD_IN] |
                   (in_v ^ PT_INV_I[(p*PLD_PT+t)*PLD_IN +: PLD_IN])));
      end
      for (int o = 0; o < PLD_OUT; o++) begin
        sop[o] = |(pt & SUM_SEL_I[(p*PLD_OUT+o)*PLD_PT +: PLD_PT]);
      end
      oreg_d = pld_rst ? '0 : (pld_run ? sop : oreg_q);
    end
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
        oreg_q <= '0;
      end else begin
        oreg_q <= oreg_d;
      end
    end
    // Combinational path is required when the output is not registered
    assign PLD_OUT_O[p*PLD_OUT +: PLD_OUT] = (sop & ~osel) | (oreg_q & osel);
  end

  // Shared ALU, shifter and mask
  always_comb begin
    cw = store_q[STORE_ADDR_I];
    op_a = cw[CW_SRCA] ? acc_v[1] : acc_v[0];
    case (pldc_srcb_e'(cw[CW_SRCB_LSB +: 2]))
      SRCB_OPR0: op_b = opr_v[0];
      SRCB_OPR1: op_b = opr_v[1];
      SRCB_ACC0: op_b = acc_v[0];
      default: op_b = acc_v[1];
    endcase
    cin = cw[CW_CHAIN_CI] & CHAIN_CARRY_I;
    sum9 = {1'b0, op_a};
    ovf = 1'b0;
    case (pldc_alu_e'(cw[CW_FN_LSB +: 3]))
      ALU_INC: begin
        sum9 = {1'b0, op_a} + 9'h001;
        ovf = (op_a == 8'h7F);
      end
      ALU_DEC: begin
        sum9 = {1'b0, op_a} - 9'h001;
        ovf = (op_a == 8'h80);
      end
      ALU_ADD: begin
        sum9 = {1'b0, op_a} + {1'b0, op_b} + {8'h00, cin};
        ovf = (op_a[7] == op_b[7]) && (sum9[7] != op_a[7]);
      end
      ALU_SUB: begin
        sum9 = {1'b0, op_a} - {1'b0, op_b} - {8'h00, cin};
        ovf = (op_a[7] != op_b[7]) && (sum9[7] != op_a[7]);
      end
      ALU_AND: sum9 = {1'b0, op_a & op_b};
      ALU_OR: sum9 = {1'b0, op_a | op_b};
      ALU_XOR: sum9 = {1'b0, op_a ^ op_b};
      default: sum9 = {1'b0, op_a};
    endcase
    alu = sum9[7:0];
    sh_out = 1'b0;
    case (pldc_shift_e'(cw[CW_SH_LSB +: 2]))
      SH_LEFT: begin
        res = {alu[6:0], CHAIN_SHIFT_I};
        sh_out = alu[7];
      end
      SH_RIGHT: begin
        res = {CHAIN_SHIFT_I, alu[7:1]};
        sh_out = alu[0];
      end
      SH_SWAP: res = {alu[3:0], alu[7:4]};
      default: res = alu;
    endcase
    if (cw[CW_MASK]) begin
      res = res | mask_q;
    end
  end

  // Per-lane accumulator, operand register and byte queue
  for (genvar i = 0; i < 2; i++) begin : g_lane
    logic [7:0] acc_q, acc_d, opr_q, opr_d, push_v;
    logic [7:0] mem_q [BQ_DEPTH];
    logic [7:0] mem_d [BQ_DEPTH];
    logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [CNW-1:0] cnt_q, cnt_d;
    logic out_mode, dp_op, hit, push, pop;
    always_comb begin
      out_mode = cfg_q[CFG_BQ0_OUT+i];
      dp_op = dp_run & cw[CW_BQ0_OP+i];
      hit = (BUS_ADDR_I == 5'(ADDR_BQ0 + 5'(i)));
      push = out_mode ? dp_op : (BUS_WR_I & hit);
      pop = out_mode ? (BUS_RD_I & hit) : dp_op;
      push_v = out_mode ? (cw[CW_PUSH_ALU] ? res : acc_q) : BUS_WDATA_I;
      push = push & (cnt_q != CNW'(BQ_DEPTH));
      pop = pop & (cnt_q != '0);
      mem_d = mem_q;
      wp_d = wp_q;
      rp_d = rp_q;
      acc_d = acc_q;
      opr_d = opr_q;
      if (push) begin
        mem_d[wp_q] = push_v;
        wp_d = PW'(wp_q + PW'(1));
      end
      if (pop) begin
        rp_d = PW'(rp_q + PW'(1));
      end
      cnt_d = CNW'(cnt_q + CNW'(push) - CNW'(pop));
      if (dp_run && cw[CW_WR_ACC0+i]) begin
        acc_d = res;
      end
      if (pop && !out_mode) begin
        if (cw[CW_LD_OPR]) begin
          opr_d = mem_q[rp_q];
        end else begin
          acc_d = mem_q[rp_q];
        end
      end
      if (BUS_WR_I && BUS_ADDR_I == 5'(ADDR_ACC0 + 5'(i))) begin
        acc_d = BUS_WDATA_I;
      end
      if (BUS_WR_I && BUS_ADDR_I == 5'(ADDR_OPR0 + 5'(i))) begin
        opr_d = BUS_WDATA_I;
      end
      if (dp_rst) begin
        acc_d = '0;
        opr_d = '0;
        wp_d = '0;
        rp_d = '0;
        cnt_d = '0;
      end
    end
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
        acc_q <= '0;
        opr_q <= '0;
        wp_q <= '0;
        rp_q <= '0;
        cnt_q <= '0;
        for (int k = 0; k < BQ_DEPTH; k++) begin
          mem_q[k] <= '0;
        end
      end else begin
        acc_q <= acc_d;
        opr_q <= opr_d;
        wp_q <= wp_d;
        rp_q <= rp_d;
        cnt_q <= cnt_d;
        mem_q <= mem_d;
      end
    end
    assign acc_v[i] = acc_q;
    assign opr_v[i] = opr_q;
    assign head_v[i] = mem_q[rp_q];
    assign cnt_v[i] = cnt_q;
  end

  // Bus side: configuration, mask, control store and read data
  always_comb begin
    cfg_d = cfg_q;
    mask_d = mask_q;
    store_d = store_q;
    rdata_d = rdata_q;
    if (BUS_WR_I) begin
      if (BUS_ADDR_I[STORE_SEL_BIT]) begin
        store_d[BUS_ADDR_I[3:1]][{BUS_ADDR_I[0], 3'h0} +: 8] = BUS_WDATA_I;
      end else if (BUS_ADDR_I == ADDR_CFG) begin
        cfg_d = BUS_WDATA_I;
      end else if (BUS_ADDR_I == ADDR_MASK) begin
        mask_d = BUS_WDATA_I;
      end
    end
    if (BUS_RD_I) begin
      if (BUS_ADDR_I[STORE_SEL_BIT]) begin
        rdata_d = store_q[BUS_ADDR_I[3:1]][{BUS_ADDR_I[0], 3'h0} +: 8];
      end else begin
        case (BUS_ADDR_I)
          ADDR_ACC0: rdata_d = acc_v[0];
          ADDR_ACC0 + 5'h01: rdata_d = acc_v[1];
          ADDR_OPR0: rdata_d = opr_v[0];
          ADDR_OPR0 + 5'h01: rdata_d = opr_v[1];
          ADDR_BQ0: rdata_d = head_v[0];
          ADDR_BQ0 + 5'h01: rdata_d = head_v[1];
          ADDR_CFG: rdata_d = cfg_q;
          ADDR_MASK: rdata_d = mask_q;
          default: rdata_d = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cfg_q <= CFG_RST;
      mask_q <= MASK_RST;
      rdata_q <= 8'h00;
      for (int k = 0; k < 8; k++) begin
        store_q[k] <= 16'h0000;
      end
    end else begin
      cfg_q <= cfg_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      store_q <= store_d;
    end
  end
  assign BUS_RDATA_O = rdata_q;

  // Registered condition and chain outputs
  logic [1:0] eq_d, lt_d, zero_d, ones_d, emp_d, full_d;
  logic ovf_d, co_d, so_d;
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      eq_d[k] = (acc_v[k] == opr_v[k]);
      lt_d[k] = (acc_v[k] < opr_v[k]);
      zero_d[k] = (acc_v[k] == 8'h00);
      ones_d[k] = (acc_v[k] == 8'hFF);
      emp_d[k] = (cnt_v[k] == '0);
      full_d[k] = (cnt_v[k] == CNW'(BQ_DEPTH));
    end
    ovf_d = dp_run & ovf;
    co_d = dp_run & sum9[8];
    so_d = dp_run & sh_out;
  end
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      CMP_EQ_O <= '0;
      CMP_LT_O <= '0;
      ZERO_O <= '0;
      ONES_O <= '0;
      BQ_EMPTY_O <= '0;
      BQ_FULL_O <= '0;
      OVFL_O <= 1'b0;
      CHAIN_CARRY_O <= 1'b0;
      CHAIN_SHIFT_O <= 1'b0;
    end else begin
      CMP_EQ_O <= eq_d;
      CMP_LT_O <= lt_d;
      ZERO_O <= zero_d;
      ONES_O <= ones_d;
      BQ_EMPTY_O <= emp_d;
      BQ_FULL_O <= full_d;
      OVFL_O <= ovf_d;
      CHAIN_CARRY_O <= co_d;
      CHAIN_SHIFT_O <= so_d;
    end
  end
endmodule : pldc_cell
`default_nettype wire

// ### pldc_host.sv
// Host processor model driving the cell's register bus.
// Assumes strobes are launched on the falling clock edge.
`timescale 1ns/100ps
`default_nettype none
module pldc_host (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output var logic [4:0] addr_o,
  output var logic wr_o,
  output var logic rd_o,
  output var logic [7:0] wdata_o
);
  initial begin
    addr_o = 5'h1F;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end
  // Strobe spans one rising edge, then one idle edge before the answer is taken
  task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d,
      output logic [7:0] q);
    addr_o = a;
    wdata_o = d;
    wr_o = w;
    rd_o = !w;
    @(negedge clk_i);
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = ~d;
    @(negedge clk_i);
    q = rdata_i;
  endtask : xfer
endmodule : pldc_host
`default_nettype wire

// ### pldc_cell_chk.sv
// Checker bound to pldc_cell: bus and flag relations at the ports.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module pldc_cell_chk
  import pldc_pkg::*;
#(
  parameter int NUM_PLD = 2,
  parameter int PLD_IN = 12,
  parameter int PLD_PT = 8,
  parameter int PLD_OUT = 4
) (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic [4:0] BUS_ADDR_I,
  input wire logic BUS_WR_I,
  input wire logic BUS_RD_I,
  input wire logic [7:0] BUS_WDATA_I,
  input wire logic [7:0] BUS_RDATA_O,
  input wire logic [NUM_PLD*PLD_PT*PLD_IN-1:0] PT_USE_I,
  input wire logic [NUM_PLD*PLD_OUT-1:0] OUT_REG_I,
  input wire logic [NUM_PLD*PLD_OUT-1:0] PLD_OUT_O,
  input wire logic [1:0] CMP_EQ_O,
  input wire logic [1:0] CMP_LT_O,
  input wire logic [1:0] ZERO_O,
  input wire logic [1:0] ONES_O,
  input wire logic [1:0] BQ_EMPTY_O,
  input wire logic [1:0] BQ_FULL_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  AST_RD_HOLD: assert property (!BUS_RD_I |=> $stable(BUS_RDATA_O))
    else $error("read data moved without a read");
  AST_UNMAPPED: assert property (BUS_RD_I && BUS_ADDR_I[4:3] == 2'h1 |=> BUS_RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  AST_MASK_RW: assert property (BUS_WR_I && !BUS_RD_I && BUS_ADDR_I == ADDR_MASK
    ##1 !BUS_WR_I ##1 BUS_RD_I && !BUS_WR_I && BUS_ADDR_I == ADDR_MASK
    |=> BUS_RDATA_O == $past(BUS_WDATA_I, 3)) else $error("mask readback wrong");
  AST_BQ_FLAGS: assert property (!(|(BQ_EMPTY_O & BQ_FULL_O)))
    else $error("queue empty and full");
  AST_CMP_EXCL: assert property (!(|(CMP_EQ_O & CMP_LT_O)))
    else $error("equal and less both set");
  AST_ZO_EXCL: assert property (!(|(ZERO_O & ONES_O)))
    else $error("zero and ones both set");
  AST_NO_TERMS: assert property (PT_USE_I == '0 && OUT_REG_I == '0 |-> PLD_OUT_O == '0)
    else $error("empty terms gave a true output");
  AST_REG_OUT: assert property ($past(PT_USE_I) == '0 && PT_USE_I == '0 |-> PLD_OUT_O == '0)
    else $error("registered output not false");
endmodule : pldc_cell_chk
bind pldc_cell pldc_cell_chk #(.NUM_PLD(NUM_PLD), .PLD_IN(PLD_IN), .PLD_PT(PLD_PT),
  .PLD_OUT(PLD_OUT)) u_chk (.CLK_I, .RESET_N_I, .BUS_ADDR_I, .BUS_WR_I, .BUS_RD_I,
  .BUS_WDATA_I, .BUS_RDATA_O, .PT_USE_I, .OUT_REG_I, .PLD_OUT_O, .CMP_EQ_O,
  .CMP_LT_O, .ZERO_O, .ONES_O, .BQ_EMPTY_O, .BQ_FULL_O);
`default_nettype wire

// ### pldc_cell_test.sv
// Self-checking bench for pldc_cell: registers, datapath, queue and arrays.
// Assumes the package, the cell, pldc_host and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module pldc_cell_test
  import pldc_pkg::*;
;
  logic clk, rst_n, route_rst, wr, rd, ovfl, ci, si, co, so;
  logic [4:0] addr;
  logic [7:0] wdata, rdata, pld_out, oreg, q8, old_sop;
  logic [2:0] saddr;
  logic [23:0] pin;
  logic [191:0] use_m, inv_m;
  logic [63:0] sum_m;
  logic [1:0] eq, lt, zero, ones, emp, full;
  int failures = 0, total_checks = 0, seed = 32'h9347, cyc = 0, a, b, e, o;
  int bq[$];
  pldc_cell dut (.CLK_I(clk), .RESET_N_I(rst_n), .BUS_ADDR_I(addr), .BUS_WR_I(wr),
    .BUS_RD_I(rd), .BUS_WDATA_I(wdata), .BUS_RDATA_O(rdata), .PLD_IN_I(pin),
    .PT_USE_I(use_m), .PT_INV_I(inv_m), .SUM_SEL_I(sum_m), .OUT_REG_I(oreg),
    .PLD_OUT_O(pld_out), .STORE_ADDR_I(saddr), .ROUTE_RESET_I(route_rst),
    .CHAIN_CARRY_I(ci), .CHAIN_SHIFT_I(si), .CHAIN_CARRY_O(co), .CHAIN_SHIFT_O(so),
    .CMP_EQ_O(eq), .CMP_LT_O(lt), .ZERO_O(zero), .ONES_O(ones), .OVFL_O(ovfl),
    .BQ_EMPTY_O(emp), .BQ_FULL_O(full));
  pldc_host host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wr_o(wr),
    .rd_o(rd), .wdata_o(wdata));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      failures = failures + 1;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task automatic w(input logic [4:0] ad, input logic [7:0] d);
    host.xfer(1'b1, ad, d, q8);
  endtask : w
  task automatic r(input logic [4:0] ad, input logic [7:0] exp);
    host.xfer(1'b0, ad, 8'h00, q8);
    chk(q8, exp);
  endtask : r
  // Result in bits 7:0, carry out in bit 8, shifted-out bit in bit 9
  function automatic int model(int k, int x, int y, int ci, int si);
    int c;
    case (k < 8 ? k : 0)
      1: x = x + 1;
      2: x = x - 1;
      3: x = x + y + ci;
      4: x = x - y - ci;
      5: x = x & y;
      6: x = x | y;
      7: x = x ^ y;
      default: ;
    endcase
    c = (k > 0 && k < 5) ? (x & 32'h100) : 0;
    x = x & 32'hFF;
    if (k == 8) c = (x & 32'h80) << 2;
    if (k == 9) c = (x & 1) << 9;
    if (k == 8) x = ((x << 1) | si) & 32'hFF;
    if (k == 9) x = (x >> 1) | (si << 7);
    if (k == 10) x = ((x << 4) | (x >> 4)) & 32'hFF;
    return x | c;
  endfunction : model
  function automatic logic [7:0] pld_model();
    logic [7:0] res;
    logic t;
    int i;
    res = 8'h00;
    for (int po = 0; po < 8; po++) begin
      for (int tt = 0; tt < 8; tt++) begin
        i = ((po / 4) * 8 + tt) * 12;
        t = (|use_m[i+:12]) && sum_m[po*8+tt];
        for (int j = 0; j < 12; j++) begin
          if (use_m[i+j] && !(pin[(po/4)*12+j] ^ inv_m[i+j])) t = 1'b0;
        end
        res[po] = res[po] | t;
      end
    end
    return res;
  endfunction : pld_model
  initial begin
    rst_n = 1'b0;
    route_rst = 1'b0;
    saddr = 3'h0;
    pin = 24'h000000;
    use_m = '0;
    inv_m = '0;
    sum_m = '0;
    oreg = 8'h00;
    ci = 1'b0;
    si = 1'b0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk({6'h00, emp}, 8'h03);
    for (int i = 0; i < 9; i++) begin
      if (i != 4 && i != 5) r(5'(i), i == 6 ? CFG_RST : 8'h00);
    end
    for (int i = 0; i < 5; i++) begin
      a = $random(seed) & 32'hFF;
      w(5'(i < 4 ? i : 7), 8'(a));
      r(5'(i < 4 ? i : 7), 8'(a));
    end
    for (int k = 0; k < 11; k++) begin
      a = $random(seed) & 32'hFF;
      b = k == 5 ? a : $random(seed) & 32'hFF;
      ci = 1'($random(seed));
      si = 1'($random(seed));
      w(ADDR_ACC0, 8'(a));
      w(ADDR_OPR0, 8'(b));
      w(5'h10, 8'(32'h80 + (k < 8 ? k : 0)));
      w(5'h11, 8'(32'h80 + (k < 8 ? 0 : k - 7)));
      e = model(k, a, b, ci, si);
      r(5'h01, 8'(e));
      r(ADDR_OPR0, 8'(b));
      chk({7'h00, eq[0]}, 8'(a == b));
      chk({7'h00, lt[0]}, 8'(a < b));
      chk({7'h00, ones[1]}, 8'((e & 32'hFF) == 32'hFF));
      chk({7'h00, co}, 8'((e >> 8) & 1));
      chk({7'h00, so}, 8'(e >> 9));
      o = k == 3 ? (a ^ e) & (b ^ e) : (a ^ b) & (a ^ e);
      if (k == 3 || k == 4) chk({7'h00, ovfl}, 8'((o >> 7) & 1));
    end
    w(5'h13, 8'h08);
    for (int i = 0; i < 5; i++) begin
      a = $random(seed) & 32'hFF;
      w(ADDR_BQ0, 8'(a));
      if (bq.size() < 4) bq.push_back(a);
    end
    chk({6'h00, full}, 8'h01);
    r(ADDR_BQ0, 8'(bq[0]));
    // Second pop goes to the operand register, the rest to the accumulator
    for (int i = 0; i < 5; i++) begin
      w(5'h13, i == 1 ? 8'h28 : 8'h08);
      saddr = 3'h1;
      @(negedge clk);
      saddr = 3'h0;
      if (bq.size() > 0) e = bq.pop_front();
      if (i == 1) r(ADDR_OPR0, 8'(e));
      else r(ADDR_ACC0, 8'(e));
    end
    chk({6'h00, emp}, 8'h03);
    w(ADDR_CFG, 8'h1C);
    route_rst = 1'b1;
    @(negedge clk);
    route_rst = 1'b0;
    r(ADDR_ACC0, 8'h00);
    r(ADDR_CFG, 8'h1C);
    chk({6'h00, zero}, 8'h03);
    // Queue one as output buffer fed by a masked increment of accumulator zero
    a = $random(seed) & 32'hFF;
    b = $random(seed) & 32'hFF;
    w(ADDR_ACC0, 8'(a));
    w(ADDR_MASK, 8'(b));
    w(5'h14, 8'h41);
    w(5'h15, 8'h54);
    w(ADDR_CFG, 8'h1E);
    saddr = 3'h2;
    repeat (4) @(negedge clk);
    saddr = 3'h0;
    for (int i = 0; i < 4; i++) begin
      a = ((a + 1) | b) & 32'hFF;
      bq.push_back(a);
    end
    @(negedge clk);
    chk({6'h00, full}, 8'h02);
    r(ADDR_ACC0, 8'(a));
    for (int i = 0; i < 4; i++) begin
      r(ADDR_BQ0 + 5'h01, 8'(bq.pop_front()));
    end
    chk({6'h00, emp}, 8'h03);
    old_sop = pld_model();
    for (int i = 0; i < 12; i++) begin
      pin = 24'($random(seed));
      use_m = {6{$random(seed) & $random(seed)}};
      inv_m = {6{$random(seed)}};
      sum_m = {2{$random(seed)}};
      oreg = 8'($random(seed));
      // Before the next edge registered outputs still show the old sum
      #1;
      chk(pld_out, (pld_model() & ~oreg) | (old_sop & oreg));
      repeat (2) @(negedge clk);
      chk(pld_out, pld_model());
      old_sop = pld_model();
    end
    // Arrays and datapath stopped, routed reset applied to the arrays only
    oreg = 8'hFF;
    repeat (2) @(negedge clk);
    old_sop = pld_model();
    w(ADDR_CFG, 8'h20);
    w(ADDR_ACC0, 8'h5A);
    pin = ~pin;
    @(negedge clk);
    chk(pld_out, old_sop);
    r(ADDR_ACC0 + 5'h01, 8'(model(10, a, 0, 0, 0)));
    route_rst = 1'b1;
    @(negedge clk);
    route_rst = 1'b0;
    chk(pld_out, 8'h00);
    r(ADDR_ACC0, 8'h5A);
    tally_and_finish();
  end
endmodule : pldc_cell_test
`default_nettype wire
